//--- mrcd_decoder.sv
// Remote command decoder: enables, status byte, function selection
`include "mrcd_consts.svh"
`default_nettype none

module mrcd_decoder (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Parsed command
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [4:0] cmd_code,
   input wire logic [15:0] cmd_value,
   // Query answer
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic rsp_is_func,
   output logic [7:0] rsp_value,
   output logic [3:0] rsp_func,
   // Events
   output logic exec_error,
   output logic trigger_pulse,
   // Status sources from neighbouring logic
   input wire logic [7:0] status_bits,
   // Visible state
   output logic [7:0] request_enable,
   output logic [7:0] status_summary_byte,
   output logic [3:0] primary_func,
   output logic [3:0] secondary_func,
   output logic four_lead_mode
);

   mrcd_pkg::mrcd_state_s r;
   mrcd_pkg::mrcd_state_s n;
   mrcd_pkg::mrcd_cmd_e cmd;

   assign cmd = mrcd_pkg::mrcd_cmd_e'(cmd_code);

   // Both select columns map onto one function code
   function automatic mrcd_pkg::mrcd_func_e func_of(
      input mrcd_pkg::mrcd_cmd_e c
   );
      case (c)
         mrcd_pkg::CMD_AC_CURRENT_SELECT,
         mrcd_pkg::CMD_AC_CURRENT_SELECT_SECONDARY: begin
            func_of = mrcd_pkg::FUNC_AC_CURRENT;
         end
         mrcd_pkg::CMD_ACDC_CURRENT_SELECT: begin
            func_of = mrcd_pkg::FUNC_ACDC_CURRENT;
         end
         mrcd_pkg::CMD_DC_CURRENT_SELECT,
         mrcd_pkg::CMD_DC_CURRENT_SELECT_SECONDARY: begin
            func_of = mrcd_pkg::FUNC_DC_CURRENT;
         end
         mrcd_pkg::CMD_CONTINUITY_SELECT: begin
            func_of = mrcd_pkg::FUNC_CONTINUITY;
         end
         mrcd_pkg::CMD_DIODE_SELECT: begin
            func_of = mrcd_pkg::FUNC_DIODE;
         end
         mrcd_pkg::CMD_FREQUENCY_SELECT,
         mrcd_pkg::CMD_FREQUENCY_SELECT_SECONDARY: begin
            func_of = mrcd_pkg::FUNC_FREQUENCY;
         end
         mrcd_pkg::CMD_RESISTANCE_SELECT,
         mrcd_pkg::CMD_RESISTANCE_SELECT_SECONDARY: begin
            func_of = mrcd_pkg::FUNC_RESISTANCE;
         end
         mrcd_pkg::CMD_AC_VOLTS_SELECT,
         mrcd_pkg::CMD_AC_VOLTS_SELECT_SECONDARY: begin
            func_of = mrcd_pkg::FUNC_AC_VOLTS;
         end
         mrcd_pkg::CMD_ACDC_VOLTS_SELECT: begin
            func_of = mrcd_pkg::FUNC_ACDC_VOLTS;
         end
         mrcd_pkg::CMD_DC_VOLTS_SELECT,
         mrcd_pkg::CMD_DC_VOLTS_SELECT_SECONDARY: begin
            func_of = mrcd_pkg::FUNC_DC_VOLTS;
         end
         default: begin
            func_of = mrcd_pkg::FUNC_NONE;
         end
      endcase
   endfunction : func_of

   function automatic logic is_acdc(input mrcd_pkg::mrcd_func_e f);
      is_acdc = (f == mrcd_pkg::FUNC_ACDC_CURRENT) ||
                (f == mrcd_pkg::FUNC_ACDC_VOLTS);
   endfunction : is_acdc

   always_comb begin
      n = r;
      n.exec_error = 1'b0;
      n.trigger_pulse = 1'b0;
      // Summary is rebuilt each cycle, so it follows sources with one cycle lag
      n.status_byte = status_bits;
      n.status_byte[`MRCD_SUMMARY_BIT] = 1'b0;
      n.status_byte[`MRCD_TOP_BIT] = 1'b0;
      n.status_byte[`MRCD_SUMMARY_BIT] = |(n.status_byte & r.req_en);
      case (r.state)
         mrcd_pkg::ST_IDLE: begin
            if (cmd_valid) begin
               case (cmd)
                  mrcd_pkg::CMD_REQUEST_ENABLE_SET: begin
                     if (cmd_value > `MRCD_ENABLE_MAX) begin
                        n.exec_error = 1'b1;
                     end else begin
                        // Binary value taken bit for bit, except summary bit 6, which is cleared
                        n.req_en = cmd_value[7:0] & ~`MRCD_SUMMARY_MASK;
                     end
                  end
                  mrcd_pkg::CMD_REQUEST_ENABLE_QUERY: begin
                     n.state = mrcd_pkg::ST_ANSWER;
                     n.cmd_ready = 1'b0;
                     n.rsp_valid = 1'b1;
                     n.rsp_is_func = 1'b0;
                     n.rsp_value = r.req_en & ~`MRCD_SUMMARY_MASK;
                  end
                  mrcd_pkg::CMD_STATUS_BYTE_QUERY: begin
                     n.state = mrcd_pkg::ST_ANSWER;
                     n.cmd_ready = 1'b0;
                     n.rsp_valid = 1'b1;
                     n.rsp_is_func = 1'b0;
                     n.rsp_value = r.status_byte;
                  end
                  mrcd_pkg::CMD_TRIGGER: begin
                     n.trigger_pulse = 1'b1;
                  end
                  mrcd_pkg::CMD_SELF_CHECK_QUERY: begin
                     n.state = mrcd_pkg::ST_ANSWER;
                     n.cmd_ready = 1'b0;
                     n.rsp_valid = 1'b1;
                     n.rsp_is_func = 1'b0;
                     n.rsp_value = `MRCD_BYTE_ZERO;
                  end
                  mrcd_pkg::CMD_WAIT_CONTINUE: begin
                     n.req_en = r.req_en;
                  end
                  mrcd_pkg::CMD_AC_CURRENT_SELECT,
                  mrcd_pkg::CMD_ACDC_CURRENT_SELECT,
                  mrcd_pkg::CMD_DC_CURRENT_SELECT,
                  mrcd_pkg::CMD_CONTINUITY_SELECT,
                  mrcd_pkg::CMD_DIODE_SELECT,
                  mrcd_pkg::CMD_FREQUENCY_SELECT,
                  mrcd_pkg::CMD_RESISTANCE_SELECT,
                  mrcd_pkg::CMD_AC_VOLTS_SELECT,
                  mrcd_pkg::CMD_ACDC_VOLTS_SELECT,
                  mrcd_pkg::CMD_DC_VOLTS_SELECT: begin
                     n.prim_func = func_of(cmd);
                     // Ac plus dc cannot share the display with a reading
                     if (is_acdc(func_of(cmd))) begin
                        n.sec_func = mrcd_pkg::FUNC_NONE;
                     end
                  end
                  mrcd_pkg::CMD_AC_CURRENT_SELECT_SECONDARY,
                  mrcd_pkg::CMD_DC_CURRENT_SELECT_SECONDARY,
                  mrcd_pkg::CMD_FREQUENCY_SELECT_SECONDARY,
                  mrcd_pkg::CMD_RESISTANCE_SELECT_SECONDARY,
                  mrcd_pkg::CMD_AC_VOLTS_SELECT_SECONDARY,
                  mrcd_pkg::CMD_DC_VOLTS_SELECT_SECONDARY: begin
                     if (is_acdc(r.prim_func)) begin
                        n.exec_error = 1'b1;
                     end else begin
                        n.sec_func = func_of(cmd);
                     end
                  end
                  mrcd_pkg::CMD_SECONDARY_CLEAR: begin
                     n.sec_func = mrcd_pkg::FUNC_NONE;
                  end
                  mrcd_pkg::CMD_PRIMARY_FUNCTION_QUERY: begin
                     n.state = mrcd_pkg::ST_ANSWER;
                     n.cmd_ready = 1'b0;
                     n.rsp_valid = 1'b1;
                     n.rsp_is_func = 1'b1;
                     n.rsp_func = r.prim_func;
                  end
                  mrcd_pkg::CMD_SECONDARY_FUNCTION_QUERY: begin
                     if (r.sec_func == mrcd_pkg::FUNC_NONE) begin
                        n.exec_error = 1'b1;
                     end else begin
                        n.state = mrcd_pkg::ST_ANSWER;
                        n.cmd_ready = 1'b0;
                        n.rsp_valid = 1'b1;
                        n.rsp_is_func = 1'b1;
                        n.rsp_func = r.sec_func;
                     end
                  end
                  mrcd_pkg::CMD_TWO_LEAD_MODE,
                  mrcd_pkg::CMD_FOUR_LEAD_MODE: begin
                     if (r.prim_func != mrcd_pkg::FUNC_RESISTANCE) begin
                        n.exec_error = 1'b1;
                     end else begin
                        n.four_lead =
                           (cmd == mrcd_pkg::CMD_FOUR_LEAD_MODE);
                     end
                  end
                  default: begin
                     n.exec_error = 1'b1;
                  end
               endcase
            end
         end
         mrcd_pkg::ST_ANSWER: begin
            // One answer outstanding; new commands wait behind it
            if (rsp_ready) begin
               n.state = mrcd_pkg::ST_IDLE;
               n.rsp_valid = 1'b0;
               n.cmd_ready = 1'b1;
            end
         end
         default: begin
            n.state = mrcd_pkg::ST_IDLE;
            n.rsp_valid = 1'b0;
            n.cmd_ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         r.state <= mrcd_pkg::ST_IDLE;
         r.cmd_ready <= 1'b1;
         r.rsp_valid <= 1'b0;
         r.rsp_is_func <= 1'b0;
         r.rsp_value <= `MRCD_BYTE_ZERO;
         r.rsp_func <= mrcd_pkg::FUNC_NONE;
         r.exec_error <= 1'b0;
         r.trigger_pulse <= 1'b0;
         r.req_en <= `MRCD_ENABLE_RESET;
         r.status_byte <= `MRCD_BYTE_ZERO;
         r.prim_func <= mrcd_pkg::FUNC_DC_VOLTS;
         r.sec_func <= mrcd_pkg::FUNC_NONE;
         r.four_lead <= 1'b0;
      end else begin
         r <= n;
      end
   end

   assign cmd_ready = r.cmd_ready;
   assign rsp_valid = r.rsp_valid;
   assign rsp_is_func = r.rsp_is_func;
   assign rsp_value = r.rsp_value;
   assign rsp_func = r.rsp_func;
   assign exec_error = r.exec_error;
   assign trigger_pulse = r.trigger_pulse;
   assign request_enable = r.req_en;
   assign status_summary_byte = r.status_byte;
   assign primary_func = r.prim_func;
   assign secondary_func = r.sec_func;
   assign four_lead_mode = r.four_lead;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   sequence s_take(logic [4:0] c);
      cmd_valid && cmd_ready && (cmd_code == c);
   endsequence

   sequence s_answer_open;
      rsp_valid && !cmd_ready;
   endsequence

   chk_enable_load: assert property (
      s_take(mrcd_pkg::CMD_REQUEST_ENABLE_SET) ##0
      (cmd_value <= `MRCD_ENABLE_MAX) |=>
      request_enable == ($past(cmd_value[7:0]) & ~`MRCD_SUMMARY_MASK))
      else $error("enable register not loaded from value");

   chk_enable_range: assert property (
      s_take(mrcd_pkg::CMD_REQUEST_ENABLE_SET) ##0
      (cmd_value > `MRCD_ENABLE_MAX) |=>
      exec_error && $stable(request_enable))
      else $error("out of range enable value not refused");

   chk_enable_query: assert property (
      s_take(mrcd_pkg::CMD_REQUEST_ENABLE_QUERY) |=>
      s_answer_open ##0 !rsp_is_func ##0
      (rsp_value == ($past(request_enable) & ~`MRCD_SUMMARY_MASK)))
      else $error("enable query answer wrong");

   chk_status_answer: assert property (
      s_take(mrcd_pkg::CMD_STATUS_BYTE_QUERY) |=>
      s_answer_open ##0 (rsp_value == $past(status_summary_byte)))
      else $error("status byte answer wrong");

   chk_summary_bit: assert property (
      ##1 status_summary_byte[`MRCD_SUMMARY_BIT] ==
      |($past(status_bits) & `MRCD_SOURCE_MASK & $past(request_enable)))
      else $error("summary bit does not follow enabled bits");

   chk_trigger_once: assert property (
      s_take(mrcd_pkg::CMD_TRIGGER) |=> trigger_pulse ##1 !trigger_pulse)
      else $error("trigger not a single pulse");

   chk_select_primary: assert property (
      s_take(mrcd_pkg::CMD_FREQUENCY_SELECT) |=>
      primary_func == mrcd_pkg::FUNC_FREQUENCY)
      else $error("primary select not applied");

   chk_primary_query: assert property (
      s_take(mrcd_pkg::CMD_PRIMARY_FUNCTION_QUERY) |=>
      s_answer_open ##0 rsp_is_func ##0 (rsp_func == $past(primary_func)))
      else $error("primary function answer wrong");

   chk_secondary_unused: assert property (
      s_take(mrcd_pkg::CMD_SECONDARY_FUNCTION_QUERY) ##0
      (secondary_func == mrcd_pkg::FUNC_NONE) |=>
      exec_error && !rsp_valid)
      else $error("unused secondary query not refused");

   chk_lead_guard: assert property (
      s_take(mrcd_pkg::CMD_FOUR_LEAD_MODE) ##0
      (primary_func != mrcd_pkg::FUNC_RESISTANCE) |=>
      exec_error && $stable(four_lead_mode))
      else $error("lead mode changed outside resistance");

   chk_acdc_block: assert property (
      s_take(mrcd_pkg::CMD_FREQUENCY_SELECT_SECONDARY) ##0
      is_acdc(mrcd_pkg::mrcd_func_e'(primary_func)) |=>
      exec_error && $stable(secondary_func))
      else $error("secondary select allowed under ac plus dc");

   chk_self_zero: assert property (
      s_take(mrcd_pkg::CMD_SELF_CHECK_QUERY) |=>
      s_answer_open ##0 (rsp_value == `MRCD_BYTE_ZERO))
      else $error("self check answer not zero");

   chk_secondary_clear: assert property (
      s_take(mrcd_pkg::CMD_SECONDARY_CLEAR) |=>
      secondary_func == mrcd_pkg::FUNC_NONE)
      else $error("secondary not cleared");

endmodule : mrcd_decoder
`default_nettype wire

//--- mrcd_consts.svh
// Constants for the meter remote command decoder
`ifndef MRCD_CONSTS_SVH
`define MRCD_CONSTS_SVH
`define MRCD_ENABLE_MAX 16'h00ff
`define MRCD_SUMMARY_BIT 6
`define MRCD_TOP_BIT 7
`define MRCD_SUMMARY_MASK 8'h40
`define MRCD_SOURCE_MASK 8'h3f
`define MRCD_BYTE_ZERO 8'h00
`define MRCD_ENABLE_RESET 8'h00
`endif

//--- mrcd_pkg.sv
// Types of the meter remote command decoder
`default_nettype none
package mrcd_pkg;
   typedef enum logic [4:0] {
      CMD_REQUEST_ENABLE_SET = 5'h00,
      CMD_REQUEST_ENABLE_QUERY = 5'h01,
      CMD_STATUS_BYTE_QUERY = 5'h02,
      CMD_TRIGGER = 5'h03,
      CMD_SELF_CHECK_QUERY = 5'h04,
      CMD_WAIT_CONTINUE = 5'h05,
      CMD_AC_CURRENT_SELECT = 5'h06,
      CMD_ACDC_CURRENT_SELECT = 5'h07,
      CMD_DC_CURRENT_SELECT = 5'h08,
      CMD_CONTINUITY_SELECT = 5'h09,
      CMD_DIODE_SELECT = 5'h0a,
      CMD_FREQUENCY_SELECT = 5'h0b,
      CMD_RESISTANCE_SELECT = 5'h0c,
      CMD_AC_VOLTS_SELECT = 5'h0d,
      CMD_ACDC_VOLTS_SELECT = 5'h0e,
      CMD_DC_VOLTS_SELECT = 5'h0f,
      CMD_AC_CURRENT_SELECT_SECONDARY = 5'h10,
      CMD_DC_CURRENT_SELECT_SECONDARY = 5'h11,
      CMD_FREQUENCY_SELECT_SECONDARY = 5'h12,
      CMD_RESISTANCE_SELECT_SECONDARY = 5'h13,
      CMD_AC_VOLTS_SELECT_SECONDARY = 5'h14,
      CMD_DC_VOLTS_SELECT_SECONDARY = 5'h15,
      CMD_SECONDARY_CLEAR = 5'h16,
      CMD_PRIMARY_FUNCTION_QUERY = 5'h17,
      CMD_SECONDARY_FUNCTION_QUERY = 5'h18,
      CMD_TWO_LEAD_MODE = 5'h19,
      CMD_FOUR_LEAD_MODE = 5'h1a
   } mrcd_cmd_e;

   typedef enum logic [3:0] {
      FUNC_NONE = 4'h0,
      FUNC_AC_CURRENT = 4'h1,
      FUNC_ACDC_CURRENT = 4'h2,
      FUNC_DC_CURRENT = 4'h3,
      FUNC_CONTINUITY = 4'h4,
      FUNC_DIODE = 4'h5,
      FUNC_FREQUENCY = 4'h6,
      FUNC_RESISTANCE = 4'h7,
      FUNC_AC_VOLTS = 4'h8,
      FUNC_ACDC_VOLTS = 4'h9,
      FUNC_DC_VOLTS = 4'ha
   } mrcd_func_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ANSWER = 2'b10
   } mrcd_state_e;

   typedef struct packed {
      mrcd_state_e state;
      logic cmd_ready;
      logic rsp_valid;
      logic rsp_is_func;
      logic [7:0] rsp_value;
      mrcd_func_e rsp_func;
      logic exec_error;
      logic trigger_pulse;
      logic [7:0] req_en;
      logic [7:0] status_byte;
      mrcd_func_e prim_func;
      mrcd_func_e sec_func;
      logic four_lead;
   } mrcd_state_s;
endpackage : mrcd_pkg
`default_nettype wire

//--- mrcd_host_model.sv
// Host side model: takes query answers at a chosen pace and keeps them
`default_nettype none
module mrcd_host_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Answer handshake
   input wire logic rsp_valid,
   output logic rsp_ready,
   input wire logic rsp_is_func,
   input wire logic [7:0] rsp_value,
   input wire logic [3:0] rsp_func,
   // Pace and last answer taken
   input wire logic [3:0] take_delay,
   output logic ans_is_func,
   output logic [7:0] ans_value,
   output logic [3:0] ans_func
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_cnt;
   // A slow host leaves the answer standing, as a busy serial link would
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rsp_ready <= 1'b0;
         wait_cnt <= 4'h0;
         ans_is_func <= 1'b0;
         ans_value <= 8'h00;
         ans_func <= 4'h0;
      end else if (rsp_valid && rsp_ready) begin
         rsp_ready <= 1'b0;
         wait_cnt <= 4'h0;
         // Answer bits are taken one for one as the register bits
         ans_is_func <= rsp_is_func;
         ans_value <= rsp_value;
         ans_func <= rsp_func;
      end else if (rsp_valid) begin
         if (wait_cnt >= take_delay) begin
            rsp_ready <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule : mrcd_host_model
`default_nettype wire

//--- test_mrcd_decoder.sv
// Self-checking bench of the remote command decoder
`default_nettype none
module test_mrcd_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [4:0] code;
      logic [15:0] val;
      logic err;
      logic [3:0] prim;
      logic [3:0] sec;
      logic [7:0] en;
      logic four;
      logic [1:0] q;
      logic [7:0] ans;
   } mrcd_row_s;
   logic clk_sys, resetn, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
   logic rsp_is_func, exec_error, trigger_pulse, four_lead_mode;
   logic ans_is_func;
   logic [4:0] cmd_code;
   logic [15:0] cmd_value;
   logic [7:0] rsp_value, status_bits, request_enable, status_summary_byte;
   logic [7:0] ans_value;
   logic [3:0] rsp_func, primary_func, secondary_func, take_delay, ans_func;
   int bad_count = 0;
   int comparisons = 0;
   // Rows: code, value, error, primary, secondary, enable, four, query, answer
   mrcd_row_s rows [0:38] = '{
      '{5'h00,16'h00c8,1'b0,4'ha,4'h0,8'h88,1'b0,2'h0,8'h00},
      '{5'h01,16'h0000,1'b0,4'ha,4'h0,8'h88,1'b0,2'h1,8'h88},
      '{5'h00,16'h0100,1'b1,4'ha,4'h0,8'h88,1'b0,2'h0,8'h00},
      '{5'h00,16'h00ff,1'b0,4'ha,4'h0,8'hbf,1'b0,2'h0,8'h00},
      '{5'h01,16'h0000,1'b0,4'ha,4'h0,8'hbf,1'b0,2'h1,8'hbf},
      '{5'h00,16'h0000,1'b0,4'ha,4'h0,8'h00,1'b0,2'h0,8'h00},
      '{5'h04,16'h0000,1'b0,4'ha,4'h0,8'h00,1'b0,2'h1,8'h00},
      '{5'h05,16'h0000,1'b0,4'ha,4'h0,8'h00,1'b0,2'h0,8'h00},
      '{5'h18,16'h0000,1'b1,4'ha,4'h0,8'h00,1'b0,2'h0,8'h00},
      '{5'h19,16'h0000,1'b1,4'ha,4'h0,8'h00,1'b0,2'h0,8'h00},
      '{5'h0c,16'h0000,1'b0,4'h7,4'h0,8'h00,1'b0,2'h0,8'h00},
      '{5'h1a,16'h0000,1'b0,4'h7,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h19,16'h0000,1'b0,4'h7,4'h0,8'h00,1'b0,2'h0,8'h00},
      '{5'h1a,16'h0000,1'b0,4'h7,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h12,16'h0000,1'b0,4'h7,4'h6,8'h00,1'b1,2'h0,8'h00},
      '{5'h18,16'h0000,1'b0,4'h7,4'h6,8'h00,1'b1,2'h2,8'h06},
      '{5'h17,16'h0000,1'b0,4'h7,4'h6,8'h00,1'b1,2'h2,8'h07},
      '{5'h10,16'h0000,1'b0,4'h7,4'h1,8'h00,1'b1,2'h0,8'h00},
      '{5'h11,16'h0000,1'b0,4'h7,4'h3,8'h00,1'b1,2'h0,8'h00},
      '{5'h13,16'h0000,1'b0,4'h7,4'h7,8'h00,1'b1,2'h0,8'h00},
      '{5'h14,16'h0000,1'b0,4'h7,4'h8,8'h00,1'b1,2'h0,8'h00},
      '{5'h15,16'h0000,1'b0,4'h7,4'ha,8'h00,1'b1,2'h0,8'h00},
      '{5'h16,16'h0000,1'b0,4'h7,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h06,16'h0000,1'b0,4'h1,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h08,16'h0000,1'b0,4'h3,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h09,16'h0000,1'b0,4'h4,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h0a,16'h0000,1'b0,4'h5,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h0b,16'h0000,1'b0,4'h6,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h0d,16'h0000,1'b0,4'h8,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h0f,16'h0000,1'b0,4'ha,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h1a,16'h0000,1'b1,4'ha,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h14,16'h0000,1'b0,4'ha,4'h8,8'h00,1'b1,2'h0,8'h00},
      '{5'h07,16'h0000,1'b0,4'h2,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h14,16'h0000,1'b1,4'h2,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h0e,16'h0000,1'b0,4'h9,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h10,16'h0000,1'b1,4'h9,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h18,16'h0000,1'b1,4'h9,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h1b,16'h0000,1'b1,4'h9,4'h0,8'h00,1'b1,2'h0,8'h00},
      '{5'h02,16'h0000,1'b0,4'h9,4'h0,8'h00,1'b1,2'h1,8'h00}
   };

   mrcd_decoder mrcd_decoder_i (
      .clk_sys(clk_sys), .resetn(resetn),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_code(cmd_code), .cmd_value(cmd_value),
      .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp_is_func(rsp_is_func), .rsp_value(rsp_value),
      .rsp_func(rsp_func), .exec_error(exec_error),
      .trigger_pulse(trigger_pulse), .status_bits(status_bits),
      .request_enable(request_enable),
      .status_summary_byte(status_summary_byte),
      .primary_func(primary_func), .secondary_func(secondary_func),
      .four_lead_mode(four_lead_mode)
   );

   mrcd_host_model mrcd_host_model_i (
      .clk_sys(clk_sys), .resetn(resetn),
      .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp_is_func(rsp_is_func), .rsp_value(rsp_value),
      .rsp_func(rsp_func), .take_delay(take_delay),
      .ans_is_func(ans_is_func), .ans_value(ans_value),
      .ans_func(ans_func)
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got,
                  exp);
      end
   endtask : chk

   task automatic give_up();
      bad_count++;
      $display("Error at %0t: handshake did not complete", $time);
      final_report();
   endtask : give_up

   // Ready is looked at mid-cycle, where it is settled for the coming edge
   task automatic send(input logic [4:0] code, input logic [15:0] val);
      int n = 0;
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd_code = code;
      cmd_value = val;
      while (cmd_ready !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      if (cmd_ready !== 1'b1) begin
         give_up();
      end
      @(negedge clk_sys);
      cmd_valid = 1'b0;
   endtask : send

   task automatic wait_answer();
      int n = 0;
      while (!(rsp_valid === 1'b1 && rsp_ready === 1'b1) && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      if (!(rsp_valid === 1'b1 && rsp_ready === 1'b1)) begin
         give_up();
      end
      @(negedge clk_sys);
   endtask : wait_answer

   initial begin
      mrcd_row_s r;
      resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd_code = 5'h00;
      cmd_value = 16'h0000;
      status_bits = 8'h00;
      take_delay = 4'h0;
      repeat (5) @(negedge clk_sys);
      resetn = 1'b1;
      for (int i = 0; i < 39; i++) begin
         r = rows[i];
         send(r.code, r.val);
         chk(8'(exec_error), 8'(r.err), "err");
         chk(8'(trigger_pulse), 8'h00, "trig");
         chk(8'(primary_func), 8'(r.prim), "prim");
         chk(8'(secondary_func), 8'(r.sec), "sec");
         chk(request_enable, r.en, "enable");
         chk(8'(four_lead_mode), 8'(r.four), "wire");
         chk(8'(rsp_valid), 8'(r.q != 2'h0), "answer");
         if (r.q != 2'h0) begin
            wait_answer();
            if (r.q == 2'h1) begin
               chk(ans_value, r.ans, "value");
               chk(8'(ans_is_func), 8'h00, "kind");
            end else begin
               chk(8'(ans_func), r.ans, "func");
               chk(8'(ans_is_func), 8'h01, "kind");
            end
         end
      end
      // Trigger lasts exactly one cycle
      send(5'h03, 16'h0000);
      chk(8'(trigger_pulse), 8'h01, "trig");
      @(negedge clk_sys);
      chk(8'(trigger_pulse), 8'h00, "trig");
      // Summary follows enabled sources only; bits 6 and 7 of sources ignored
      send(5'h00, 16'h0001);
      status_bits = 8'hc1;
      @(negedge clk_sys);
      chk(status_summary_byte, 8'h41, "status");
      send(5'h02, 16'h0000);
      wait_answer();
      chk(ans_value, 8'h41, "status");
      status_bits = 8'h02;
      @(negedge clk_sys);
      chk(status_summary_byte, 8'h02, "status");
      // Slow host: the answer stands and no command is taken meanwhile
      take_delay = 4'h3;
      send(5'h01, 16'h0000);
      chk(8'(cmd_ready), 8'h00, "ready");
      @(negedge clk_sys);
      @(negedge clk_sys);
      chk(8'(rsp_valid), 8'h01, "answer");
      wait_answer();
      chk(ans_value, 8'h01, "value");
      take_delay = 4'h0;
      // Reset in mid-run returns the visible state to its start
      resetn = 1'b0;
      @(negedge clk_sys);
      chk(request_enable, 8'h00, "enable");
      chk(8'(primary_func), 8'h0a, "prim");
      chk(8'(secondary_func), 8'h00, "sec");
      chk(8'(four_lead_mode), 8'h00, "wire");
      resetn = 1'b1;
      send(5'h0c, 16'h0000);
      chk(8'(primary_func), 8'h07, "prim");
      final_report();
   end
endmodule : test_mrcd_decoder
`default_nettype wire
